// ---- shared/abu_pkg.sv ----
// Constants, types and register map of the address breakpoint unit
package abu_pkg;

    // Register byte offsets on the bus
    localparam logic [7:0] ABU_OFS_CTRL   = 8'h00;
    localparam logic [7:0] ABU_OFS_ADDR_H = 8'h04;
    localparam logic [7:0] ABU_OFS_ADDR_L = 8'h08;
    localparam logic [7:0] ABU_OFS_WAKE   = 8'h0c;
    localparam logic [7:0] ABU_OFS_FLAGC  = 8'h10;

    // Field positions
    localparam int ABU_BIT_ENABLE  = 7;
    localparam int ABU_BIT_ACTIVE  = 6;
    localparam int ABU_BIT_WAIT    = 1;
    localparam int ABU_BIT_CLR_EN  = 7;

    // Reset values
    localparam logic [7:0] ABU_RST_BYTE = 8'h00;
    localparam logic [2:0] ABU_RST_SYNC = 3'h0;

    // Bus slave handshake states, one-hot
    typedef enum logic [1:0] {
        ABU_BUS_IDLE = 2'b01,
        ABU_BUS_ACK  = 2'b10
    } abu_bus_type;

    // Core-side status inputs, same clock as the unit
    typedef struct packed {
        logic [15:0] pc_addr;   // Program counter address
        logic        pc_fetch;  // Address is a fetch by the core
        logic        in_wait;   // Core sits in wait mode
        logic        in_stop;   // Core sits in stop mode
        logic        in_break;  // Core runs break handler
    } abu_core_type;

    // Whole state of the unit
    typedef struct packed {
        abu_bus_type bus;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        enable;
        logic        active;
        logic [7:0]  addr_h;
        logic [7:0]  addr_l;
        logic        wait_flag;
        logic        clr_en;
        logic [2:0]  tst_sync;
        logic        tst_level;
        logic        brk_req;
        logic        timer_halt;
        logic        wdog_off;
        logic        flag_clr_ok;
    } abu_state_type;

endpackage

// ---- verilog/abu_top.sv ----
// Address breakpoint unit: APB registers, comparator and break controls
`timescale 1ns/1ps
`default_nettype none
module abu_top (
    input  wire logic                  clk,         // 10 MHz system clock
    input  wire logic                  rst_b,       // Async reset, low
    input  wire logic                  psel,        // APB select
    input  wire logic                  penable,     // APB access phase
    input  wire logic                  pwrite,      // APB write
    input  wire logic [7:0]            paddr,       // APB byte address
    input  wire logic [31:0]           pwdata,      // APB write data
    output logic      [31:0]           prdata,      // APB read data
    output logic                       pready,      // APB ready
    output logic                       pslverr,     // APB error
    input  wire abu_pkg::abu_core_type core_i,      // Core status
    input  wire logic                  tst_voltage, // Test level on reset pin
    output logic                       brk_req,     // Break request to core
    output logic                       timer_halt,  // Halt both timers
    output logic                       wdog_off,    // Disable watchdog
    output logic                       flag_clr_ok  // Status clears allowed
);
    import abu_pkg::*;

    abu_state_type s_r;    // Registered state
    abu_state_type s_nxt;  // Next state
    // One struct for every flop keeps the reset branch and the
    // register stage in step as fields are added.

    logic        acc;       // Access phase completes this cycle
    logic        wr_take;   // Write completes this edge
    logic        hit;       // Address compare result
    logic        map_ok;    // Address is mapped
    logic [31:0] rd_word;   // Read mux output

    // The slave always adds one wait state. A master that lowers
    // penable before ready only restarts the access from idle, so
    // no half-finished write can land.
    // Access completes only on the ready edge
    assign acc     = psel && penable && s_r.pready;
    assign wr_take = acc && pwrite && map_ok;

    // Only fetch addresses are compared: a data access to the
    // break address must not stop the core. Both bytes come
    // straight from their flops, so a half-written pair can hit;
    // program the pair with breaks disabled.
    // Full 16-bit comparison, only on core fetches
    assign hit = core_i.pc_fetch
              && (core_i.pc_addr == {s_r.addr_h, s_r.addr_l});

    // Unmapped offsets read zero and raise the error response;
    // upper bits of every register word read zero.
    // Address decode and read mux
    always_comb begin
        map_ok  = 1'b1;
        rd_word = 32'h0000_0000;
        case (paddr)
            ABU_OFS_CTRL: begin
                rd_word[ABU_BIT_ENABLE] = s_r.enable;
                rd_word[ABU_BIT_ACTIVE] = s_r.active;
            end
            ABU_OFS_ADDR_H: rd_word[7:0] = s_r.addr_h;
            ABU_OFS_ADDR_L: rd_word[7:0] = s_r.addr_l;
            ABU_OFS_WAKE:   rd_word[ABU_BIT_WAIT] = s_r.wait_flag;
            ABU_OFS_FLAGC:  rd_word[ABU_BIT_CLR_EN] = s_r.clr_en;
            default:        map_ok = 1'b0;
        endcase
    end

    // Next-state logic for the whole unit
    always_comb begin
        s_nxt = s_r;

        // Read data is latched with ready, so it stands exactly in
        // the cycle in which the master samples it.
        // Bus handshake: one wait state, ready in second access cycle
        case (s_r.bus)
            ABU_BUS_IDLE: begin
                s_nxt.pready  = 1'b0;
                s_nxt.pslverr = 1'b0;
                if (psel && penable) begin
                    s_nxt.bus     = ABU_BUS_ACK;
                    s_nxt.pready  = 1'b1;
                    s_nxt.pslverr = !map_ok;
                    s_nxt.prdata  = pwrite ? 32'h0000_0000 : rd_word;
                end
            end
            ABU_BUS_ACK: begin
                // Drop ready after the completing edge
                s_nxt.bus     = ABU_BUS_IDLE;
                s_nxt.pready  = 1'b0;
                s_nxt.pslverr = 1'b0;
            end
            default: begin
                s_nxt.bus    = ABU_BUS_IDLE;
                s_nxt.pready = 1'b0;
            end
        endcase

        // Writes land only on the completing edge; the hardware
        // set paths come later in this process, so a match or a
        // wake in the same cycle beats a software clear.
        // Software writes; plain stores on completing edge
        if (wr_take) begin
            case (paddr)
                ABU_OFS_CTRL: begin
                    s_nxt.enable = pwdata[ABU_BIT_ENABLE];
                    s_nxt.active = pwdata[ABU_BIT_ACTIVE];
                end
                ABU_OFS_ADDR_H: s_nxt.addr_h = pwdata[7:0];
                ABU_OFS_ADDR_L: s_nxt.addr_l = pwdata[7:0];
                ABU_OFS_WAKE:
                    s_nxt.wait_flag = pwdata[ABU_BIT_WAIT];
                ABU_OFS_FLAGC:  s_nxt.clr_en = pwdata[ABU_BIT_CLR_EN];
                default: begin
                end
            endcase
        end

        // Wait mode does not gate the comparator, so a fetch match
        // still breaks while the core waits.
        // Match sets the flag; set beats a same-cycle clear.
        // Stop mode freezes the comparator but keeps registers.
        if (s_r.enable && hit && !core_i.in_stop) begin
            s_nxt.active = 1'b1;
        end

        // The wake flag is the handler's cue to step the stacked
        // return address back onto the wait opcode.
        // A break leaving wait mode marks the wake flag
        if (s_r.brk_req && core_i.in_wait) begin
            s_nxt.wait_flag = 1'b1;
        end

        // The test level comes from a pin outside this clock, so it
        // is taken only once the last two stages agree; a glitch
        // shorter than a cycle never reaches the watchdog control.
        // Test level sampled through three flops
        s_nxt.tst_sync = {s_r.tst_sync[1:0], tst_voltage};
        if (s_r.tst_sync[1] == s_r.tst_sync[2]) begin
            s_nxt.tst_level = s_r.tst_sync[2];
        end

        // The request is built from the next flag value, so it rises
        // on the same edge as the flag and costs no extra cycle.
        // Request stays up while flagged and core neither in break nor in stop.
        // Core clears the flag in its handler, so no re-entry.
        s_nxt.brk_req = s_nxt.active && !core_i.in_break
                     && !core_i.in_stop;

        // These follow the core's own break state, not the request,
        // so timers stay frozen through the whole handler and run
        // again one cycle after the return.
        // Break-side controls follow the core's break state
        s_nxt.timer_halt  = core_i.in_break;
        s_nxt.wdog_off    = core_i.in_break && s_r.tst_level;
        s_nxt.flag_clr_ok = !core_i.in_break || s_r.clr_en;
    end

    // Asynchronous reset loads constants only; flag_clr_ok comes
    // up high so status clears work normally out of reset.
    // State register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_r.bus         <= ABU_BUS_IDLE;
            s_r.prdata      <= 32'h0000_0000;
            s_r.pready      <= 1'b0;
            s_r.pslverr     <= 1'b0;
            s_r.enable      <= 1'b0;
            s_r.active      <= 1'b0;
            s_r.addr_h      <= ABU_RST_BYTE;
            s_r.addr_l      <= ABU_RST_BYTE;
            s_r.wait_flag   <= 1'b0;
            s_r.clr_en      <= 1'b0;
            s_r.tst_sync    <= ABU_RST_SYNC;
            s_r.tst_level   <= 1'b0;
            s_r.brk_req     <= 1'b0;
            s_r.timer_halt  <= 1'b0;
            s_r.wdog_off    <= 1'b0;
            s_r.flag_clr_ok <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // No logic sits between flops and pins, so output timing is
    // one clock-to-out and nothing glitches toward the core.
    // Outputs straight from the state flops
    assign prdata      = s_r.prdata;
    assign pready      = s_r.pready;
    assign pslverr     = s_r.pslverr;
    assign brk_req     = s_r.brk_req;
    assign timer_halt  = s_r.timer_halt;
    assign wdog_off    = s_r.wdog_off;
    assign flag_clr_ok = s_r.flag_clr_ok;

    // Assertions watch only what the unit drives; core inputs
    // appear in antecedents as conditions, except in a_wdog_needs_tst, whose consequent checks $past(core_i.in_break).
    // Checks on the unit's own outputs
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_match_sets_active: assert property (
        (s_r.enable && hit && !core_i.in_stop) |=> s_r.active)
        else $error("match did not set active flag");

    a_req_follows_flag: assert property (
        (s_r.active && !core_i.in_break && !core_i.in_stop
         && !(wr_take && paddr == ABU_OFS_CTRL))
        |=> s_r.brk_req)
        else $error("no request while flag set");

    a_timer_halt_track: assert property (
        core_i.in_break |=> timer_halt)
        else $error("timers not halted in break");

    a_wdog_needs_tst: assert property (
        wdog_off |-> $past(core_i.in_break) && $past(s_r.tst_level))
        else $error("watchdog off without cause");

    a_stop_no_req: assert property (
        core_i.in_stop |=> !brk_req)
        else $error("request during stop");

    a_disabled_no_set: assert property (
        (!s_r.enable && !s_r.active && !wr_take) |=> !s_r.active)
        else $error("flag set while disabled");

    a_addr_reg_hold: assert property (
        !wr_take |=> $stable({s_r.addr_h, s_r.addr_l}))
        else $error("address changed without write");

    a_wait_wake_set: assert property (
        (brk_req && core_i.in_wait) |=> s_r.wait_flag)
        else $error("wait flag not set on wake");

    a_clear_gated: assert property (
        (core_i.in_break && !s_r.clr_en) |=> !flag_clr_ok)
        else $error("clears allowed in break");

    a_ready_one_cycle: assert property (
        pready |=> !pready)
        else $error("ready held two cycles");

    // Bus slave: error only with ready, one wait state always
    a_ready_after_wait: assert property (
        (psel && penable && !pready) |=> pready)
        else $error("no ready after access cycle");

    a_err_with_ready: assert property (
        pslverr |-> pready)
        else $error("error without ready");

    a_err_on_hole: assert property (
        (psel && penable && !pready && !map_ok) |=> pslverr)
        else $error("no error for unmapped offset");

    // Break request: follows the flag, dropped one cycle after break starts
    a_req_needs_flag: assert property (
        brk_req |-> s_r.active)
        else $error("request without active flag");

    a_soft_sets_req: assert property (
        (wr_take && paddr == ABU_OFS_CTRL && pwdata[ABU_BIT_ACTIVE]
         && !core_i.in_break && !core_i.in_stop) |=> brk_req)
        else $error("flag write raised no request");

    a_break_drops_req: assert property (
        core_i.in_break |=> !brk_req)
        else $error("request held inside break");

    // Control register stores
    a_enable_set: assert property (
        (wr_take && paddr == ABU_OFS_CTRL && pwdata[ABU_BIT_ENABLE])
        |=> s_r.enable)
        else $error("enable bit not stored");

    a_enable_clear: assert property (
        (wr_take && paddr == ABU_OFS_CTRL && !pwdata[ABU_BIT_ENABLE])
        |=> !s_r.enable)
        else $error("enable bit not cleared");

    a_enable_hold: assert property (
        !(wr_take && paddr == ABU_OFS_CTRL) |=> $stable(s_r.enable))
        else $error("enable bit changed without write");

    a_active_clear: assert property (
        (wr_take && paddr == ABU_OFS_CTRL && !pwdata[ABU_BIT_ACTIVE]
         && !(s_r.enable && hit && !core_i.in_stop)) |=> !s_r.active)
        else $error("active flag not cleared");

    a_stop_keeps_flag: assert property (
        (core_i.in_stop && !wr_take) |=> $stable(s_r.active))
        else $error("active flag moved in stop");

    // Address bytes take the written low byte
    a_addr_h_store: assert property (
        (wr_take && paddr == ABU_OFS_ADDR_H)
        |=> ({24'h00_0000, s_r.addr_h} == ($past(pwdata) & 32'h0000_00ff)))
        else $error("high address byte not stored");

    a_addr_l_store: assert property (
        (wr_take && paddr == ABU_OFS_ADDR_L)
        |=> ({24'h00_0000, s_r.addr_l} == ($past(pwdata) & 32'h0000_00ff)))
        else $error("low address byte not stored");

    // Wake flag and clear-enable bit
    a_wait_hold: assert property (
        (!wr_take && !(brk_req && core_i.in_wait))
        |=> $stable(s_r.wait_flag))
        else $error("wait flag moved by itself");

    a_wait_clear: assert property (
        (wr_take && paddr == ABU_OFS_WAKE && !pwdata[ABU_BIT_WAIT]
         && !(brk_req && core_i.in_wait)) |=> !s_r.wait_flag)
        else $error("wait flag not cleared");

    a_clr_en_hold: assert property (
        !(wr_take && paddr == ABU_OFS_FLAGC) |=> $stable(s_r.clr_en))
        else $error("clear enable changed without write");

    a_clear_free: assert property (
        (!core_i.in_break || s_r.clr_en) |=> flag_clr_ok)
        else $error("clears blocked outside break");

    // Timer halt and watchdog follow the break state
    a_timer_runs: assert property (
        !core_i.in_break |=> !timer_halt)
        else $error("timers halted outside break");

    a_wdog_on_tst: assert property (
        (core_i.in_break && s_r.tst_level) |=> wdog_off)
        else $error("watchdog left on in break");

    a_tst_settle: assert property (
        (s_r.tst_sync[1] != s_r.tst_sync[2]) |=> $stable(s_r.tst_level))
        else $error("test level taken before settling");

    c_stop_match: cover property (
        core_i.in_stop && s_r.enable && hit);

    c_match_break: cover property (
        s_r.enable && hit ##1 brk_req ##[1:20] core_i.in_break);
    c_soft_break: cover property (
        wr_take && paddr == ABU_OFS_CTRL && pwdata[ABU_BIT_ACTIVE]
        ##1 brk_req);
    c_wait_wake: cover property (brk_req && core_i.in_wait);
    c_bad_addr: cover property (pready && pslverr);

endmodule
`default_nettype wire

// ---- verif/abu_core_model.sv ----
// Behavioural core: takes break requests, leaves break on return
`timescale 1ns/1ps
`default_nettype none
module abu_core_model (
    input  wire logic clk,      // System clock
    input  wire logic rst_b,    // Async reset, low
    input  wire logic brk_req,  // Break request from unit
    input  wire logic return_from_interrupt_opcode,      // Return from interrupt executed
    input  wire logic slow,     // Long instruction still running
    output var  logic in_break  // Break handler running
);
    logic [1:0] left_r; // Cycles of current instruction done

    // Finish the instruction, then enter break; return leaves it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            in_break <= 1'b0;
            left_r   <= 2'h0;
        end else if (return_from_interrupt_opcode) begin
            in_break <= 1'b0;
        end else if (brk_req && !in_break) begin
            if (!slow || left_r == 2'h2) begin
                in_break <= 1'b1;
                left_r   <= 2'h0;
            end else begin
                left_r <= left_r + 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- verif/abu_tb_top.sv ----
// Self-checking bench of the address breakpoint unit
`timescale 1ns/1ps
`default_nettype none
module abu_tb_top;
    import abu_pkg::*;
    logic        clk = 1'b0, rst_b = 1'b0;        // Clock, reset
    logic        psel = 1'b0, penable = 1'b0;     // APB controls
    logic        pwrite = 1'b0, er;               // Direction, error
    logic [7:0]  paddr = 8'h00;                   // APB address
    logic [31:0] pwdata = 32'h0, prdata, rd;      // Bus data
    logic        pready, pslverr, hit;            // Answer, request seen
    logic [15:0] pc = 16'h0;                      // Program counter
    logic        fetch = 1'b0, wt = 1'b0;         // Fetch, wait mode
    logic        stp = 1'b0, inb, tst = 1'b0;     // Stop, break, test
    logic        return_from_interrupt_opcode = 1'b0, slow = 1'b0;         // Model controls
    logic        brk_req, timer_halt, wdog_off, flag_clr_ok; // Outputs
    abu_core_type core;                           // Core status bundle
    int          n_errors = 0, n_compared = 0, cyc = 0; // Counters
    logic [7:0]  ofs [5] = '{ABU_OFS_ADDR_H, ABU_OFS_ADDR_L,
                             ABU_OFS_FLAGC, ABU_OFS_WAKE, 8'h14}; // Rows
    logic [7:0]  wd [5] = '{8'h12, 8'h34, 8'h80, 8'h00, 8'h5a}; // Written
    logic [7:0]  ev [5] = '{8'h12, 8'h34, 8'h80, 8'h00, 8'h00}; // Read
    logic        ee [5] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h1}; // Error

    assign core = '{pc, fetch, wt, stp, inb};

    abu_top abu_top_inst (.clk(clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .core_i(core), .tst_voltage(tst),
        .brk_req(brk_req), .timer_halt(timer_halt),
        .wdog_off(wdog_off), .flag_clr_ok(flag_clr_ok));
    abu_core_model abu_core_model_inst (.clk(clk), .rst_b(rst_b),
        .brk_req(brk_req), .return_from_interrupt_opcode(return_from_interrupt_opcode), .slow(slow), .in_break(inb));

    // 100 ns clock
    initial begin
        forever #50 clk = ~clk;
    end

    // Hang guard, well above the whole sequence
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            report_and_stop();
        end
    end

    task automatic chk(input string nm, input logic [31:0] s, e);
        n_compared++;
        if (s !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, s);
        end
    endtask

    // One APB transfer; answer taken at the edge pready is seen
    task automatic apb(input logic w, input logic [7:0] a, d);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1 && cyc < 20000);
        rd      = prdata;
        er      = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // One fetch at an address, then watch for a request
    task automatic match(input logic [15:0] a);
        @(posedge clk);
        pc    <= a;
        fetch <= 1'b1;
        @(posedge clk);
        fetch <= 1'b0;
        hit = 1'b0;
        repeat (8) begin
            @(posedge clk);
            hit = hit | brk_req;
        end
    endtask

    // Handler fetches its vector, clears active flag, then returns
    task automatic leave;
        match(16'hfffc);
        apb(1'b1, ABU_OFS_CTRL, 8'h80);
        @(posedge clk);
        return_from_interrupt_opcode <= 1'b1;
        @(posedge clk);
        return_from_interrupt_opcode <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    task automatic report_and_stop;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, ofs[i], wd[i]);
            chk("error flag", er, ee[i]);
            apb(1'b0, ofs[i], 8'h00);
            chk("read back", rd, ev[i]);
            chk("read error", er, ee[i]);
        end
        match(16'h1234);
        chk("break while disabled", hit, 32'h0);
        apb(1'b1, ABU_OFS_CTRL, 8'h80);
        match(16'h1235);
        chk("break on near address", hit, 32'h0);
        tst  <= 1'b1;
        slow <= 1'b1;
        match(16'h1234);
        chk("break on match", hit, 32'h1);
        apb(1'b0, ABU_OFS_CTRL, 8'h00);
        chk("control after match", rd, 32'hc0);
        chk("timer halt", timer_halt, 32'h1);
        chk("watchdog off", wdog_off, 32'h1);
        chk("clear allowed", flag_clr_ok, 32'h1);
        apb(1'b1, ABU_OFS_FLAGC, 8'h00);
        repeat (3) @(posedge clk);
        chk("clear blocked", flag_clr_ok, 32'h0);
        leave();
        chk("timer runs", timer_halt, 32'h0);
        chk("watchdog back", wdog_off, 32'h0);
        slow <= 1'b0;
        tst  <= 1'b0;
        apb(1'b1, ABU_OFS_CTRL, 8'hc0);
        @(posedge clk);
        chk("request on write", brk_req, 32'h1);
        repeat (3) @(posedge clk);
        chk("watchdog needs test level", wdog_off, 32'h0);
        chk("timer halt on soft break", timer_halt, 32'h1);
        leave();
        wt <= 1'b1;
        match(16'h1234);
        apb(1'b0, ABU_OFS_WAKE, 8'h00);
        chk("wake flag", rd, 32'h2);
        wt <= 1'b0;
        leave();
        match(16'h1233);
        chk("break at wait opcode", hit, 32'h0);
        apb(1'b1, ABU_OFS_WAKE, 8'h00);
        apb(1'b0, ABU_OFS_WAKE, 8'h00);
        chk("wake flag cleared", rd, 32'h0);
        stp <= 1'b1;
        match(16'h1234);
        chk("break in stop", hit, 32'h0);
        apb(1'b0, ABU_OFS_ADDR_L, 8'h00);
        chk("address kept", rd, 32'h34);
        stp   <= 1'b0;
        apb(1'b1, ABU_OFS_CTRL, 8'hc0);
        repeat (3) @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        chk("request in reset", brk_req, 32'h0);
        chk("timer halt in reset", timer_halt, 32'h0);
        chk("clears in reset", flag_clr_ok, 32'h1);
        rst_b <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, ofs[i], 8'h00);
            chk("reset value", rd, 32'h0);
        end
        apb(1'b0, ABU_OFS_CTRL, 8'h00);
        chk("control reset", rd, 32'h0);
        report_and_stop();
    end
endmodule
`default_nettype wire
